// *** rtl/lke_params.svh ***
// Constants for the legacy keyboard emulation block
// Notes on behaviour
// - Strap pin high makes emulation available
// - Registers at 100h, 104h, 108h, 10Ch
// - Config mode bit qualifies port interception
// - Mode low: intercept regardless of base
// - Mode high: intercept only when base 60h
// - Registers reachable via memory and I/O
// - Enabled: ports 60h/64h map to registers
// - Read 64h returns status, no side effect
// - Write 60h: store, full=1, cmd flag=0
// - Write 64h: store, full=1, cmd flag=1
// - Read 60h returns output, clears output-full unless software writes status in the same cycle
// - Input buffer holds last port byte
// - Enable bit activates port decode and interrupts
// - Output full raises keyboard or mouse interrupt
// - Input full holds emulation interrupt active
// - Pending and output empty raise emulation interrupt
`ifndef LKE_PARAMS_SVH
`define LKE_PARAMS_SVH

// Register offsets in the memory window
`define LKE_OFS_CONTROL     12'h100
`define LKE_OFS_INPUT       12'h104
`define LKE_OFS_OUTPUT      12'h108
`define LKE_OFS_STATUS      12'h10c

// Legacy keyboard ports and required companion base
`define LKE_PORT_DATA       16'h0060
`define LKE_PORT_CMD        16'h0064
`define LKE_IO_BASE_REQ     16'h0060

// Control field positions
`define LKE_CTL_EMU_ON      0
`define LKE_CTL_EMU_IRQ     1
`define LKE_CTL_CHAR_PEND   2
`define LKE_CTL_IRQ_ALLOW   3

// Status field positions
`define LKE_ST_OBF          0
`define LKE_ST_IBF          1
`define LKE_ST_CMD_DATA     3
`define LKE_ST_AUX          5

// Reset values
`define LKE_RST_BYTE        8'h00
`define LKE_RST_STATUS      8'h00

`endif

// *** rtl/lke_pkg.sv ***
// Types for the legacy keyboard emulation block
`include "lke_params.svh"

package lke_pkg;

  // Register selected by a window offset
  typedef enum logic [4:0] {
    LKE_SEL_NONE = 5'b00001,
    LKE_SEL_CTRL = 5'b00010,
    LKE_SEL_IN   = 5'b00100,
    LKE_SEL_OUT  = 5'b01000,
    LKE_SEL_STAT = 5'b10000
  } lke_sel_e;

  // State of the top module, apart from the strap synchroniser flops
  typedef struct packed {
    logic        emulation_on;
    logic        character_pending_a;
    logic        legacy_irq_allow;
    logic [7:0]  input_byte;
    logic [7:0]  output_byte;
    logic [7:0]  status;
    logic        mem_ack;
    logic [31:0] mem_rdata;
    logic        io_ack;
    logic        io_claim;
    logic [31:0] io_rdata;
    logic        keyboard_interrupt;
    logic        mouse_interrupt;
    logic        emulation_irq;
  } lke_state_s;

  // Map a window offset onto a register; unmapped gives none
  function automatic lke_sel_e lke_sel_of(input logic [11:0] ofs);
    lke_sel_e sel;
    sel = LKE_SEL_NONE;
    if (ofs == `LKE_OFS_CONTROL) sel = LKE_SEL_CTRL;
    if (ofs == `LKE_OFS_INPUT)   sel = LKE_SEL_IN;
    if (ofs == `LKE_OFS_OUTPUT)  sel = LKE_SEL_OUT;
    if (ofs == `LKE_OFS_STATUS)  sel = LKE_SEL_STAT;
    return sel;
  endfunction : lke_sel_of

endpackage : lke_pkg

// *** rtl/lke_sync.sv ***
// Two-stage synchroniser for the legacy strap pin
`timescale 1ns/10ps
`default_nettype none

module lke_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  // Asynchronous level in, synchronised level out
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_ff;
  logic sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : lke_sync

`default_nettype wire

// *** rtl/lke_decode.sv ***
// I/O address decode: legacy ports and the register window in I/O space
`timescale 1ns/10ps
`default_nettype none

`include "lke_params.svh"

module lke_decode (
  // I/O address and qualifiers
  input  wire logic        [15:0] io_addr_i,
  input  wire logic        [15:0] io_base_i,
  input  wire logic               legc_mode_i,
  input  wire logic               avail_i,
  input  wire logic               emu_on_i,
  // Decode results
  output logic                    hit_data_o,
  output logic                    hit_cmd_o,
  output lke_pkg::lke_sel_e       win_sel_o
);

  logic [15:0] rel_addr;
  logic        base_ok;
  logic        port_en;

  // Mode low ignores the companion base; mode high waits for 60h
  assign base_ok = legc_mode_i ? (io_base_i == `LKE_IO_BASE_REQ) : 1'b1;
  assign port_en = avail_i & emu_on_i & base_ok;
  assign hit_data_o = port_en & (io_addr_i == `LKE_PORT_DATA);
  assign hit_cmd_o  = port_en & (io_addr_i == `LKE_PORT_CMD);

  // Register window also sits in I/O space, relative to the companion base
  assign rel_addr  = io_addr_i - io_base_i;
  assign win_sel_o = (avail_i && rel_addr[15:12] == 4'h0) ? lke_pkg::lke_sel_of(rel_addr[11:0])
                                                          : lke_pkg::LKE_SEL_NONE;

endmodule : lke_decode

`default_nettype wire

// *** rtl/lke_top.sv ***
// Legacy keyboard and mouse emulation registers and port interception
`timescale 1ns/10ps
`default_nettype none

`include "lke_params.svh"

module lke_top (
  // Clock, reset and clock enable
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // Strap pin and configuration inputs
  input  wire logic        legacy_strap_i,
  input  wire logic        legc_mode_i,
  input  wire logic [15:0] io_base_i,
  // Memory window access from the host controller driver
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [11:0] mem_addr_i,
  input  wire logic [31:0] mem_wdata_i,
  output logic             mem_ack_o,
  output logic      [31:0] mem_rdata_o,
  // I/O space access
  input  wire logic        io_req_i,
  input  wire logic        io_we_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic [31:0] io_wdata_i,
  output logic             io_ack_o,
  output logic             io_claim_o,
  output logic      [31:0] io_rdata_o,
  // Interrupt lines
  output logic             keyboard_interrupt_o,
  output logic             mouse_interrupt_o,
  output logic             emulation_irq_o
);

  lke_pkg::lke_state_s st_ff;
  lke_pkg::lke_state_s nxt_st;

  logic              avail;
  logic              hit_data;
  logic              hit_cmd;
  lke_pkg::lke_sel_e io_sel;
  lke_pkg::lke_sel_e mem_sel;

  // Strap comes from a pin, so it is synchronised first
  lke_sync u_strap_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .async_i (legacy_strap_i),
    .sync_o  (avail)
  );

  // Port and window decode for the I/O side
  lke_decode u_decode (
    .io_addr_i   (io_addr_i),
    .io_base_i   (io_base_i),
    .legc_mode_i (legc_mode_i),
    .avail_i     (avail),
    .emu_on_i    (st_ff.emulation_on),
    .hit_data_o  (hit_data),
    .hit_cmd_o   (hit_cmd),
    .win_sel_o   (io_sel)
  );

  // Memory window decode; strap low hides the whole set
  assign mem_sel = avail ? lke_pkg::lke_sel_of(mem_addr_i) : lke_pkg::LKE_SEL_NONE;

  // Read value of one register; reserved bits are zero
  function automatic logic [31:0] reg_read(input lke_pkg::lke_state_s s, input lke_pkg::lke_sel_e sel);
    logic [31:0] v;
    logic        emu_irq;
    v = 32'h0000_0000;
    emu_irq = s.emulation_on & (s.status[`LKE_ST_IBF] | (s.character_pending_a & ~s.status[`LKE_ST_OBF]));
    unique case (sel)
      lke_pkg::LKE_SEL_NONE: v = 32'h0000_0000;
      lke_pkg::LKE_SEL_CTRL: begin
        v[`LKE_CTL_EMU_ON]    = s.emulation_on;
        v[`LKE_CTL_EMU_IRQ]   = emu_irq;
        v[`LKE_CTL_CHAR_PEND] = s.character_pending_a;
        v[`LKE_CTL_IRQ_ALLOW] = s.legacy_irq_allow;
      end
      lke_pkg::LKE_SEL_IN:   v[7:0] = s.input_byte;
      lke_pkg::LKE_SEL_OUT:  v[7:0] = s.output_byte;
      lke_pkg::LKE_SEL_STAT: v[7:0] = s.status;
    endcase
    return v;
  endfunction : reg_read

  // Software write of one register; only the low byte fields exist
  function automatic lke_pkg::lke_state_s reg_write(input lke_pkg::lke_state_s s, input lke_pkg::lke_sel_e sel,
                                                    input logic [31:0] d);
    lke_pkg::lke_state_s r;
    r = s;
    unique case (sel)
      lke_pkg::LKE_SEL_NONE: r = s;
      lke_pkg::LKE_SEL_CTRL: begin
        // The emulation interrupt bit is derived, so it takes no write
        r.emulation_on        = d[`LKE_CTL_EMU_ON];
        r.character_pending_a = d[`LKE_CTL_CHAR_PEND];
        r.legacy_irq_allow    = d[`LKE_CTL_IRQ_ALLOW];
      end
      lke_pkg::LKE_SEL_IN:   r.input_byte  = d[7:0];
      lke_pkg::LKE_SEL_OUT:  r.output_byte = d[7:0];
      lke_pkg::LKE_SEL_STAT: r.status      = d[7:0];
    endcase
    return r;
  endfunction : reg_write

  // Next-state logic: memory side first, then I/O side effects on top
  always_comb begin
    logic sw_status_wr;
    sw_status_wr = 1'b0;
    nxt_st = st_ff;
    nxt_st.mem_ack   = 1'b0;
    nxt_st.io_ack    = 1'b0;
    nxt_st.io_claim  = 1'b0;
    nxt_st.io_rdata  = 32'h0000_0000;

    // Memory window; unmapped offsets read zero and drop writes
    if (mem_req_i) begin
      nxt_st.mem_ack   = 1'b1;
      nxt_st.mem_rdata = reg_read(st_ff, mem_sel);
      if (mem_we_i) begin
        nxt_st = reg_write(nxt_st, mem_sel, mem_wdata_i);
        sw_status_wr = (mem_sel == lke_pkg::LKE_SEL_STAT);
      end
    end

    // I/O space: every request is answered, claim tells if it was ours
    if (io_req_i) begin
      nxt_st.io_ack = 1'b1;
      if (io_sel != lke_pkg::LKE_SEL_NONE) begin
        nxt_st.io_claim = 1'b1;
        // Writes return zero data, the same as the legacy ports
        if (io_we_i) begin
          nxt_st = reg_write(nxt_st, io_sel, io_wdata_i);
          sw_status_wr = sw_status_wr | (io_sel == lke_pkg::LKE_SEL_STAT);
        end else begin
          nxt_st.io_rdata = reg_read(st_ff, io_sel);
        end
      end else if (hit_data) begin
        nxt_st.io_claim = 1'b1;
        if (io_we_i) begin
          // Hardware set of the full flag wins over a same-cycle software clear
          nxt_st.input_byte                = io_wdata_i[7:0];
          nxt_st.status[`LKE_ST_IBF]       = 1'b1;
          nxt_st.status[`LKE_ST_CMD_DATA]  = 1'b0;
        end else begin
          nxt_st.io_rdata[7:0] = st_ff.output_byte;
          // A software set in the same cycle is kept rather than lost
          if (!sw_status_wr) begin
            nxt_st.status[`LKE_ST_OBF] = 1'b0;
          end
        end
      end else if (hit_cmd) begin
        nxt_st.io_claim = 1'b1;
        if (io_we_i) begin
          nxt_st.input_byte                = io_wdata_i[7:0];
          nxt_st.status[`LKE_ST_IBF]       = 1'b1;
          nxt_st.status[`LKE_ST_CMD_DATA]  = 1'b1;
        end else begin
          nxt_st.io_rdata[7:0] = st_ff.status;
        end
      end
    end

    // Interrupt lines follow the settled next state, so they are registered
    nxt_st.keyboard_interrupt = avail & nxt_st.emulation_on & nxt_st.legacy_irq_allow &
                                nxt_st.status[`LKE_ST_OBF] & ~nxt_st.status[`LKE_ST_AUX];
    nxt_st.mouse_interrupt    = avail & nxt_st.emulation_on & nxt_st.legacy_irq_allow &
                                nxt_st.status[`LKE_ST_OBF] & nxt_st.status[`LKE_ST_AUX];
    nxt_st.emulation_irq      = avail & nxt_st.emulation_on &
                                (nxt_st.status[`LKE_ST_IBF] |
                                 (nxt_st.character_pending_a & ~nxt_st.status[`LKE_ST_OBF]));
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff <= '{emulation_on: 1'b0, character_pending_a: 1'b0, legacy_irq_allow: 1'b0,
                 input_byte: `LKE_RST_BYTE, output_byte: `LKE_RST_BYTE, status: `LKE_RST_STATUS,
                 mem_ack: 1'b0, mem_rdata: 32'h0000_0000, io_ack: 1'b0, io_claim: 1'b0,
                 io_rdata: 32'h0000_0000, keyboard_interrupt: 1'b0, mouse_interrupt: 1'b0,
                 emulation_irq: 1'b0};
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign mem_ack_o            = st_ff.mem_ack;
  assign mem_rdata_o          = st_ff.mem_rdata;
  assign io_ack_o             = st_ff.io_ack;
  assign io_claim_o           = st_ff.io_claim;
  assign io_rdata_o           = st_ff.io_rdata;
  assign keyboard_interrupt_o = st_ff.keyboard_interrupt;
  assign mouse_interrupt_o    = st_ff.mouse_interrupt;
  assign emulation_irq_o      = st_ff.emulation_irq;

endmodule : lke_top

`default_nettype wire

// *** verification/lke_monitor.sv ***
// Port checker for the legacy keyboard emulation block
`timescale 1ns/10ps
`default_nettype none

module lke_monitor (
  // Clock, reset and qualifiers
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        legacy_strap_i,
  input  wire logic        legc_mode_i,
  input  wire logic [15:0] io_base_i,
  input  wire logic [15:0] io_addr_i,
  // Requests and answers
  input  wire logic        mem_req_i,
  input  wire logic        io_req_i,
  input  wire logic        io_we_i,
  input  wire logic        mem_ack_o,
  input  wire logic        io_ack_o,
  input  wire logic        io_claim_o,
  input  wire logic [31:0] mem_rdata_o,
  input  wire logic [31:0] io_rdata_o,
  // Interrupt lines
  input  wire logic        keyboard_interrupt_o,
  input  wire logic        mouse_interrupt_o,
  input  wire logic        emulation_irq_o
);
  default clocking mon_cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Answers come one cycle after each request; memory answers never come without one
  chk_mem_answer: assert property (mem_req_i |=> mem_ack_o)
    else $error("memory access not answered");
  chk_mem_quiet: assert property (!mem_req_i |=> !mem_ack_o)
    else $error("memory answer without request");
  chk_io_answer: assert property (io_req_i |=> io_ack_o)
    else $error("port access not answered");
  chk_claim_idle: assert property (!io_ack_o |-> !io_claim_o && io_rdata_o == 32'h0)
    else $error("claim or data outside answer");
  chk_write_quiet: assert property (io_req_i && io_we_i |=> io_rdata_o == 32'h0)
    else $error("port write returned data");
  // Reserved upper bits of every register read as zero
  chk_mem_upper: assert property (mem_ack_o |-> mem_rdata_o[31:8] == 24'h0)
    else $error("memory read upper bits set");
  chk_io_upper: assert property (io_ack_o |-> io_rdata_o[31:8] == 24'h0)
    else $error("port read upper bits set");
  // Three low samples cover the two-stage strap synchroniser
  chk_strap_off: assert property (!legacy_strap_i [*3] |=> !io_claim_o && !keyboard_interrupt_o
    && !mouse_interrupt_o && !emulation_irq_o)
    else $error("activity with strap low");
  // Base limit keeps the I/O window clear of the legacy ports
  chk_mode_gate: assert property (io_req_i && legc_mode_i && io_base_i != 16'h0060
    && io_base_i < 16'hfe00 && (io_addr_i == 16'h0060 || io_addr_i == 16'h0064) |=> !io_claim_o)
    else $error("port claimed with wrong base");
  chk_irq_excl: assert property (!(keyboard_interrupt_o && mouse_interrupt_o))
    else $error("keyboard and mouse both raised");
endmodule : lke_monitor

bind lke_top lke_monitor u_lke_monitor (.clk_i(clk_i), .reset_i(reset_i), .legacy_strap_i(legacy_strap_i),
  .legc_mode_i(legc_mode_i), .io_base_i(io_base_i), .io_addr_i(io_addr_i), .mem_req_i(mem_req_i),
  .io_req_i(io_req_i), .io_we_i(io_we_i), .mem_ack_o(mem_ack_o), .io_ack_o(io_ack_o),
  .io_claim_o(io_claim_o), .mem_rdata_o(mem_rdata_o), .io_rdata_o(io_rdata_o),
  .keyboard_interrupt_o(keyboard_interrupt_o), .mouse_interrupt_o(mouse_interrupt_o),
  .emulation_irq_o(emulation_irq_o));
`default_nettype wire

// *** verification/lke_host.sv ***
// Host processor model issuing legacy port accesses
`timescale 1ns/10ps
`default_nettype none

module lke_host (
  // Clock and answer from the block
  input  wire logic        clk_i,
  input  wire logic        claim_i,
  input  wire logic [31:0] rdata_i,
  // Port request
  output logic             req_o,
  output logic             we_o,
  output logic      [15:0] addr_o,
  output logic      [31:0] wdata_o
);
  logic        claim;
  logic [31:0] rd;

  // Idle bus at time zero
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 16'h0;
    wdata_o = 32'h0;
  end

  // One-cycle request; released address and data lines show the inverse so stale values never pass
  task automatic io(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_i);
    req_o = 1'b1;
    we_o = w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    req_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    claim = claim_i;
    rd = rdata_i;
  endtask : io
endmodule : lke_host
`default_nettype wire

// *** verification/tb_legacy_keyboard_emulation.sv ***
// Self-checking bench for the legacy keyboard emulation block
`timescale 1ns/10ps
`default_nettype none

module tb_legacy_keyboard_emulation;
  logic        clk_i, reset_i, ce_i, strap, mode, mreq, mwe, mack;
  logic [15:0] base;
  logic [11:0] maddr;
  logic [31:0] mwd, mrd, rd, seed;
  wire logic        ireq, iwe, iack, iclaim, kbd, mou, emi;
  wire logic [15:0] iaddr;
  wire logic [31:0] iwd, ird;
  int          fail_count, tests_run, ctl, ib, ob, st;

  lke_top u_lke_top (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .legacy_strap_i(strap),
    .legc_mode_i(mode), .io_base_i(base), .mem_req_i(mreq), .mem_we_i(mwe), .mem_addr_i(maddr),
    .mem_wdata_i(mwd), .mem_ack_o(mack), .mem_rdata_o(mrd), .io_req_i(ireq), .io_we_i(iwe),
    .io_addr_i(iaddr), .io_wdata_i(iwd), .io_ack_o(iack), .io_claim_o(iclaim), .io_rdata_o(ird),
    .keyboard_interrupt_o(kbd), .mouse_interrupt_o(mou), .emulation_irq_o(emi));
  lke_host u_lke_host (.clk_i(clk_i), .claim_i(iclaim), .rdata_i(ird), .req_o(ireq), .we_o(iwe),
    .addr_o(iaddr), .wdata_o(iwd));

  // Free-running clock, 4 ns period
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // Memory window access; the answer is fixed one cycle after the request
  task automatic mem(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_i);
    mreq = 1'b1;
    mwe = w;
    maddr = a;
    mwd = d;
    @(negedge clk_i);
    mreq = 1'b0;
    maddr = ~a;
    chk("mem_ack", 1, mack);
    rd = mrd;
  endtask : mem

  // Interrupt levels expected from the model state
  task automatic irqs();
    logic on;
    on = strap && ctl[0];
    chk("kbd_irq", on && ctl[3] && st[0] && !st[5], kbd);
    chk("mouse_irq", on && ctl[3] && st[0] && st[5], mou);
    chk("emu_irq", on && (st[1] || (ctl[2] && !st[0])), emi);
  endtask : irqs

  task automatic final_report();
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    final_report();
  end

  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    strap = 1'b1;
    mode = 1'b0;
    base = 16'h0200;
    {mreq, mwe, maddr, mwd} = '0;
    seed = 32'h00014663;
    {fail_count, tests_run, ctl, ib, ob, st} = '0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) reset_i = 1'b0;
    repeat (4) @(negedge clk_i);
    irqs();
    mem(0, 12'h0fc, 0);
    chk("unmapped", 0, rd);
    mem(1, 12'h100, 32'hfffffff9);
    ctl = 9;
    mem(0, 12'h100, 0);
    chk("control", ctl, rd);
    // Alternate data and command port writes with random bytes
    for (int i = 0; i < 8; i++) begin
      u_lke_host.io(1, (i % 2) ? 16'h0064 : 16'h0060, xs());
      ib = seed[7:0];
      st = ((st | 2) & ~8) | (i % 2) * 8;
      chk("claim", 1, u_lke_host.claim);
      chk("port_wr_data", 0, u_lke_host.rd);
      irqs();
      mem(0, 12'h104, 0);
      chk("input", ib, rd);
      mem(0, 12'h10c, 0);
      chk("status", st, rd);
    end
    // Output buffer full, keyboard then mouse; upper write bits must not stick
    for (int a = 0; a < 2; a++) begin
      ob = xs() & 255;
      mem(1, 12'h108, ob | 32'hff00);
      mem(0, 12'h108, 0);
      chk("output", ob, rd);
      st = 1 | a * 32;
      mem(1, 12'h10c, st);
      irqs();
      u_lke_host.io(0, 16'h0064, 0);
      chk("port64", st, u_lke_host.rd);
      irqs();
      u_lke_host.io(0, 16'h0060, 0);
      st = st & ~1;
      chk("port60", ob, u_lke_host.rd);
      irqs();
    end
    mem(1, 12'h100, 5);
    ctl = 5;
    irqs();
    mem(0, 12'h100, 0);
    chk("control", ctl | 2, rd);
    st = 1;
    mem(1, 12'h10c, st);
    irqs();
    // Mode and companion base qualify interception; firmware sets base 60h
    for (int k = 0; k < 3; k++) begin
      mode = k > 0;
      base = (k == 2) ? 16'h0060 : 16'h0200;
      u_lke_host.io(0, 16'h0064, 0);
      chk("mode_claim", k != 1, u_lke_host.claim);
    end
    u_lke_host.io(0, 16'h016c, 0);
    chk("io_window", st, u_lke_host.rd);
    // Window write through I/O space lands in the output buffer, returns no data
    u_lke_host.io(1, 16'h0168, 32'h5a);
    chk("io_win_wr", 0, u_lke_host.rd);
    mem(0, 12'h108, 0);
    chk("io_win_out", 32'h5a, rd);
    mem(1, 12'h100, 0);
    ctl = 0;
    u_lke_host.io(1, 16'h0060, 32'h33);
    chk("off_claim", 0, u_lke_host.claim);
    mem(0, 12'h10c, 0);
    chk("status", st, rd);
    strap = 1'b0;
    repeat (3) @(negedge clk_i);
    mem(0, 12'h104, 0);
    chk("strap_low", 0, rd);
    irqs();
    final_report();
  end
endmodule : tb_legacy_keyboard_emulation
`default_nettype wire
